// ### design/clk_gen_regs.sv
// Clock and reset generator registers on a classic Wishbone port
// Assumes source ticks, flash trim and lock sense are synchronous
`timescale 1ns/1ps
`include "clk_gen_consts.svh"
module clk_gen_regs #(
    parameter int STARTUP_CYCLES = `OSC_STARTUP_CYC
) (
    // Clock, reset, enable
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    input wire logic por_in,
    // Wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [9:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // System events
    input wire logic stop_mode_in,
    input wire logic illegal_access_in,
    input wire logic fll_in_tolerance_in,
    input wire logic [8:0] flash_trim_in,
    // Clock source ticks
    input wire logic dco_tick_in,
    input wire logic osc_tick_in,
    // Clock outputs
    output logic core_tick_out,
    output logic bus_tick_out,
    output logic dco_enable_out,
    // Loop control
    output logic fll_ref_select_out,
    output logic [10:0] fll_factor_out,
    output logic [8:0] trim_out,
    // Status
    output logic lock_irq_out,
    output logic osc_monitor_enable_out,
    output logic osc_enable_out
);
    import clk_gen_pkg::*;

    crg_state_t q;
    crg_state_t d;
    logic osc_started;
    logic req;
    logic wr;
    logic [7:0] idx;
    logic [7:0] wbyte;
    logic lock_clear;
    logic lock_set_flag;
    logic src_tick;
    logic [3:0] div_lim;
    logic [7:0] rbyte;

    // Startup timer counts in 16 bits
    if (STARTUP_CYCLES < 1 || STARTUP_CYCLES > 65535) begin : g_bad_startup
        $error("clk_gen_regs: STARTUP_CYCLES out of range");
    end

    osc_startup_timer #(
        .CYCLES(STARTUP_CYCLES)
    ) u_timer (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .enable_in(q.osc_enable && !stop_mode_in),
        .started_out(osc_started)
    );

    always_comb begin
        req = wb_cyc_in && wb_stb_in;
        idx = wb_adr_in[9:2];
        wbyte = wb_dat_in[7:0];
        wr = req && wb_we_in && q.ack && wb_sel_in[0];
        lock_clear = stop_mode_in || (wr &&
            (idx == `IDX_CLOCK_CONTROL_ZERO ||
             idx == `IDX_LOOP_MULTIPLIER ||
             idx == `IDX_REFERENCE_TRIM_HIGH ||
             idx == `IDX_REFERENCE_TRIM_LOW));
        src_tick = q.bus_source_select ? osc_tick_in : dco_tick_in;
        div_lim = (q.core_divider_field == `DIV_CODE_TOP) ?
            `DIV_LIMIT_TOP : q.core_divider_field;
        rbyte = 8'h00;
        case (idx)
            `IDX_CLOCK_CONTROL_ZERO: begin
                rbyte[`POS_OSC_ENABLE] = q.osc_enable;
                rbyte[`POS_REF_DIV_LO +: 3] = q.reference_divider;
                rbyte[`POS_BUS_SOURCE_SELECT] = q.bus_source_select;
                rbyte[`POS_REFERENCE_SELECT] = q.reference_select;
            end
            `IDX_CLOCK_DIVIDER_CONTROL: begin
                rbyte[`POS_CORE_DIV_LO +: 4] = q.core_divider_field;
                rbyte[`POS_LOCK_IRQ_ENABLE] = q.lock_irq_enable;
            end
            `IDX_LOOP_MULTIPLIER: begin
                rbyte[6:0] = q.multiplier_field;
            end
            `IDX_CLOCK_STATUS_FLAGS: begin
                rbyte[`POS_POWER_ON_FLAG] = q.power_on_flag;
                rbyte[`POS_LOCK_IRQ_FLAG] = q.lock_irq_flag;
                rbyte[`POS_LOCK_STATE] = q.lock_state;
                rbyte[`POS_ILLEGAL_ACCESS_FLAG] = q.illegal_access_flag;
                rbyte[`POS_OSC_STARTED] = osc_started;
            end
            `IDX_REFERENCE_TRIM_HIGH: begin
                rbyte[`POS_TRIM_BIT8] = q.trim[8];
            end
            `IDX_REFERENCE_TRIM_LOW: begin
                rbyte = q.trim[7:0];
            end
            default: begin
                rbyte = 8'h00;
            end
        endcase

        d = q;
        // Bus handshake: one wait state, ack for one cycle
        d.ack = req && !q.ack;
        d.rdat = {24'h00_0000, rbyte};

        // Register writes, accepted at the ack edge
        if (wr) begin
            case (idx)
                `IDX_CLOCK_CONTROL_ZERO: begin
                    d.osc_enable = wbyte[`POS_OSC_ENABLE];
                    d.reference_divider = wbyte[`POS_REF_DIV_LO +: 3];
                    d.bus_source_select = wbyte[`POS_BUS_SOURCE_SELECT] &&
                        osc_started && wbyte[`POS_OSC_ENABLE];
                    d.reference_select = wbyte[`POS_REFERENCE_SELECT] &&
                        osc_started && wbyte[`POS_OSC_ENABLE];
                end
                `IDX_CLOCK_DIVIDER_CONTROL: begin
                    d.core_divider_field = wbyte[`POS_CORE_DIV_LO +: 4];
                    d.lock_irq_enable = wbyte[`POS_LOCK_IRQ_ENABLE];
                end
                `IDX_LOOP_MULTIPLIER: begin
                    d.multiplier_field = wbyte[6:0];
                end
                `IDX_REFERENCE_TRIM_HIGH: begin
                    d.trim[8] = wbyte[`POS_TRIM_BIT8];
                end
                `IDX_REFERENCE_TRIM_LOW: begin
                    d.trim[7:0] = wbyte;
                end
                default: begin
                end
            endcase
        end
        if (!q.osc_enable || stop_mode_in) begin
            d.bus_source_select = 1'b0;
            d.reference_select = 1'b0;
        end

        // Lock state tracking
        d.lock_block = lock_clear || (q.lock_block && fll_in_tolerance_in);
        d.lock_state = !lock_clear && fll_in_tolerance_in &&
            !q.lock_block;
        lock_set_flag = !lock_clear && (d.lock_state != q.lock_state);

        // Flags: hardware set wins over write-one clear
        if (lock_set_flag) begin
            d.lock_irq_flag = 1'b1;
        end else if (wr && idx == `IDX_CLOCK_STATUS_FLAGS &&
                     wbyte[`POS_LOCK_IRQ_FLAG]) begin
            d.lock_irq_flag = 1'b0;
        end
        if (illegal_access_in) begin
            d.illegal_access_flag = 1'b1;
        end else if (wr && idx == `IDX_CLOCK_STATUS_FLAGS &&
                     wbyte[`POS_ILLEGAL_ACCESS_FLAG]) begin
            d.illegal_access_flag = 1'b0;
        end
        if (wr && idx == `IDX_CLOCK_STATUS_FLAGS &&
            wbyte[`POS_POWER_ON_FLAG]) begin
            d.power_on_flag = 1'b0;
        end

        // Core divider and bus halving
        d.core_tick = 1'b0;
        d.bus_tick = 1'b0;
        if (src_tick) begin
            if (q.div_cnt >= div_lim) begin
                d.div_cnt = 4'h0;
                d.core_tick = 1'b1;
                d.bus_phase = !q.bus_phase;
                d.bus_tick = q.bus_phase;
            end else begin
                d.div_cnt = q.div_cnt + 4'h1;
            end
        end

        // Trim load after reset release
        case (q.phase)
            PH_TRIM_LOAD: begin
                d.trim = flash_trim_in;
                d.phase = PH_RUN;
            end
            PH_RUN: begin
            end
            default: begin
                d.phase = PH_TRIM_LOAD;
            end
        endcase

        // System reset: flags that survive it are left alone
        if (!nrst_in) begin
            d.phase = PH_TRIM_LOAD;
            d.ack = 1'b0;
            d.rdat = 32'h0000_0000;
            d.osc_enable = 1'b0;
            d.reference_divider = 3'h0;
            d.bus_source_select = 1'b0;
            d.reference_select = 1'b0;
            d.core_divider_field = 4'h0;
            d.lock_irq_enable = 1'b0;
            d.multiplier_field = `RST_MULT7;
            d.lock_irq_flag = 1'b0;
            d.lock_state = 1'b0;
            d.lock_block = 1'b0;
            d.trim = `RST_TRIM9;
            d.div_cnt = 4'h0;
            d.bus_phase = 1'b0;
            d.core_tick = 1'b0;
            d.bus_tick = 1'b0;
        end
        if (por_in) begin
            d.power_on_flag = 1'b1;
            d.illegal_access_flag = 1'b0;
        end

        // Registered outputs
        d.irq = d.lock_irq_enable && d.lock_irq_flag;
        d.factor = `FLL_BASE_FACTOR +
            {3'b000, d.multiplier_field, 1'b0};
        d.dco_enable = !d.bus_source_select;
    end

    always_ff @(posedge mclk_in) begin
        if (ce_in) begin
            q <= d;
        end
    end

    assign wb_dat_out = q.rdat;
    assign wb_ack_out = q.ack;
    assign core_tick_out = q.core_tick;
    assign bus_tick_out = q.bus_tick;
    assign dco_enable_out = q.dco_enable;
    assign fll_ref_select_out = q.reference_select;
    assign fll_factor_out = q.factor;
    assign trim_out = q.trim;
    assign lock_irq_out = q.irq;
    assign osc_monitor_enable_out = osc_started;
    assign osc_enable_out = q.osc_enable;

    property p_factor;
        @(posedge mclk_in) disable iff (!nrst_in)
        fll_factor_out == 11'(1000 + 2 * q.multiplier_field);
    endproperty
    a_factor: assert property (p_factor)
        else $error("loop factor mismatch");

    property p_irq;
        @(posedge mclk_in) disable iff (!nrst_in)
        lock_irq_out |-> (q.lock_irq_flag && q.lock_irq_enable);
    endproperty
    a_irq: assert property (p_irq)
        else $error("lock request without flag and enable");

    property p_mult_clear;
        @(posedge mclk_in) disable iff (!nrst_in)
        (ce_in && wr && idx == `IDX_LOOP_MULTIPLIER && !q.lock_irq_flag)
        |=> (!q.lock_state && !q.lock_irq_flag);
    endproperty
    a_mult_clear: assert property (p_mult_clear)
        else $error("multiplier write did not clear lock silently");

    property p_ila_keep;
        @(posedge mclk_in) disable iff (!nrst_in)
        (ce_in && wr && idx == `IDX_CLOCK_STATUS_FLAGS &&
         !wbyte[`POS_ILLEGAL_ACCESS_FLAG] && !por_in)
        |=> $stable(q.illegal_access_flag) || q.illegal_access_flag;
    endproperty
    a_ila_keep: assert property (p_ila_keep)
        else $error("illegal flag cleared by zero write");

    property p_ila_set;
        @(posedge mclk_in) disable iff (!nrst_in)
        (ce_in && illegal_access_in && !por_in) |=> q.illegal_access_flag;
    endproperty
    a_ila_set: assert property (p_ila_set)
        else $error("illegal access not flagged");

    property p_lock_flag;
        @(posedge mclk_in) disable iff (!nrst_in)
        (ce_in && !lock_clear && !q.lock_block &&
         fll_in_tolerance_in != q.lock_state) |=> q.lock_irq_flag;
    endproperty
    a_lock_flag: assert property (p_lock_flag)
        else $error("lock change not flagged");

    property p_src_gate;
        @(posedge mclk_in) disable iff (!nrst_in)
        (q.bus_source_select || q.reference_select) |-> osc_started;
    endproperty
    a_src_gate: assert property (p_src_gate)
        else $error("crystal selected before startup");

    property p_osc_off;
        @(posedge mclk_in) disable iff (!nrst_in)
        (ce_in && !q.osc_enable) |=> !osc_started;
    endproperty
    a_osc_off: assert property (p_osc_off)
        else $error("startup status kept while disabled");

    property p_trimh;
        @(posedge mclk_in) disable iff (!nrst_in)
        (ce_in && req && !wb_we_in && !q.ack &&
         idx == `IDX_REFERENCE_TRIM_HIGH) |=> wb_dat_out[31:1] == 31'h0;
    endproperty
    a_trimh: assert property (p_trimh)
        else $error("trim high upper bits not zero");

    property p_bus_half;
        @(posedge mclk_in) disable iff (!nrst_in)
        bus_tick_out |-> core_tick_out;
    endproperty
    a_bus_half: assert property (p_bus_half)
        else $error("bus tick without core tick");

    property p_por;
        @(posedge mclk_in)
        (ce_in && por_in) |=> q.power_on_flag;
    endproperty
    a_por: assert property (p_por)
        else $error("power-on flag not set");

    c_lock: cover property (@(posedge mclk_in) $rose(q.lock_state));
    c_irq: cover property (@(posedge mclk_in) $rose(lock_irq_out));
    c_osc: cover property (@(posedge mclk_in) $rose(q.bus_source_select));
endmodule : clk_gen_regs

// ### inc/clk_gen_consts.svh
// Constants of the clock generator register block
// Assumes a 32-bit classic Wishbone slave port at 250 MHz
`ifndef CLK_GEN_CONSTS_SVH
`define CLK_GEN_CONSTS_SVH

// Register indexes; byte address is four times the index
`define IDX_CLOCK_CONTROL_ZERO 8'h34
`define IDX_CLOCK_DIVIDER_CONTROL 8'h35
`define IDX_LOOP_MULTIPLIER 8'h36
`define IDX_CLOCK_STATUS_FLAGS 8'h37
`define IDX_REFERENCE_TRIM_HIGH 8'h38
`define IDX_REFERENCE_TRIM_LOW 8'h39

// Field positions
`define POS_OSC_ENABLE 7
`define POS_REF_DIV_LO 4
`define POS_BUS_SOURCE_SELECT 3
`define POS_REFERENCE_SELECT 2
`define POS_CORE_DIV_LO 4
`define POS_LOCK_IRQ_ENABLE 1
`define POS_POWER_ON_FLAG 6
`define POS_LOCK_IRQ_FLAG 4
`define POS_LOCK_STATE 3
`define POS_ILLEGAL_ACCESS_FLAG 2
`define POS_OSC_STARTED 1
`define POS_TRIM_BIT8 0

// Reset values
`define RST_CTRL8 8'h00
`define RST_MULT7 7'h00
`define RST_TRIM9 9'h000

// Divider and multiplier constants
`define DIV_CODE_TOP 4'hf
`define DIV_LIMIT_TOP 4'he
`define FLL_BASE_FACTOR 11'h3e8

// Timing
`define CLK_MHZ 250
`define OSC_STARTUP_NS 100000
`define OSC_STARTUP_CYC ((`OSC_STARTUP_NS * `CLK_MHZ + 999) / 1000)

`endif

// ### inc/clk_gen_pkg.sv
// Types of the clock generator register block
// Assumes the constants header is on the include path
package clk_gen_pkg;
    `include "clk_gen_consts.svh"

    typedef enum logic [0:0] {
        PH_TRIM_LOAD = 1'b0,
        PH_RUN = 1'b1
    } phase_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic started;
    } timer_state_t;

    typedef struct packed {
        phase_t phase;
        logic ack;
        logic [31:0] rdat;
        logic osc_enable;
        logic [2:0] reference_divider;
        logic bus_source_select;
        logic reference_select;
        logic [3:0] core_divider_field;
        logic lock_irq_enable;
        logic [6:0] multiplier_field;
        logic power_on_flag;
        logic lock_irq_flag;
        logic lock_state;
        logic lock_block;
        logic illegal_access_flag;
        logic [8:0] trim;
        logic [3:0] div_cnt;
        logic bus_phase;
        logic core_tick;
        logic bus_tick;
        logic irq;
        logic [10:0] factor;
        logic dco_enable;
    } crg_state_t;
endpackage : clk_gen_pkg

// ### design/osc_startup_timer.sv
// Oscillator startup timer: flags startup after a fixed enabled time
// Assumes enable is synchronous to the block clock
`timescale 1ns/1ps
module osc_startup_timer #(
    parameter int CYCLES = 25000
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    // Control and status
    input wire logic enable_in,
    output logic started_out
);
    import clk_gen_pkg::*;

    timer_state_t q;
    timer_state_t d;

    // Counter is 16 bits wide
    if (CYCLES < 1 || CYCLES > 65535) begin : g_bad_cycles
        $error("osc_startup_timer: CYCLES out of range");
    end

    always_comb begin
        d = q;
        if (!nrst_in || !enable_in) begin
            d.cnt = 16'h0000;
            d.started = 1'b0;
        end else if (!q.started) begin
            if (q.cnt == 16'(CYCLES - 1)) begin
                d.started = 1'b1;
            end else begin
                d.cnt = q.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (ce_in) begin
            q <= d;
        end
    end

    assign started_out = q.started;
endmodule : osc_startup_timer

// ### verif/tb_clk_gen_regs.sv
// Self-checking bench for the clock generator register block
// Assumes the constants header and package are compiled first
`timescale 1ns/1ps
`include "clk_gen_consts.svh"
module tb_clk_gen_regs;
    import clk_gen_pkg::*;
    localparam logic [7:0] CTL0 = `IDX_CLOCK_CONTROL_ZERO;
    localparam logic [7:0] CTL1 = `IDX_CLOCK_DIVIDER_CONTROL;
    localparam logic [7:0] MULT = `IDX_LOOP_MULTIPLIER;
    localparam logic [7:0] FLAGS = `IDX_CLOCK_STATUS_FLAGS;
    localparam logic [7:0] TRIMH = `IDX_REFERENCE_TRIM_HIGH;
    localparam logic [7:0] TRIML = `IDX_REFERENCE_TRIM_LOW;
    localparam int ILA = 0;
    localparam int TOL = 1;
    localparam int STOP = 2;
    logic mclk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic ce_in = 1'b1;
    logic por_in = 1'b1;
    logic wb_cyc_in = 1'b0;
    logic wb_stb_in = 1'b0;
    logic wb_we_in = 1'b0;
    logic [9:0] wb_adr_in = 10'h000;
    logic [3:0] wb_sel_in = 4'hf;
    logic [31:0] wb_dat_in = 32'h0000_0000;
    logic [31:0] wb_dat_out;
    logic wb_ack_out;
    logic stop_mode_in = 1'b0;
    logic illegal_access_in = 1'b0;
    logic fll_in_tolerance_in = 1'b0;
    logic [8:0] flash_trim_in = 9'h1a5;
    logic dco_tick_in = 1'b1;
    logic osc_tick_in = 1'b0;
    logic core_tick_out, bus_tick_out, dco_enable_out, fll_ref_select_out;
    logic [10:0] fll_factor_out;
    logic [8:0] trim_out;
    logic lock_irq_out, osc_monitor_enable_out, osc_enable_out;
    int n_mismatch = 0;
    int checks = 0;
    int i;
    logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h2, 4'hc, 4'hf};
    int divs [5] = '{1, 2, 3, 13, 15};

    clk_gen_regs #(.STARTUP_CYCLES(8)) u_dut (
        .mclk_in(mclk_in), .nrst_in(nrst_in), .ce_in(ce_in),
        .por_in(por_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
        .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
        .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
        .wb_ack_out(wb_ack_out), .stop_mode_in(stop_mode_in),
        .illegal_access_in(illegal_access_in),
        .fll_in_tolerance_in(fll_in_tolerance_in),
        .flash_trim_in(flash_trim_in), .dco_tick_in(dco_tick_in),
        .osc_tick_in(osc_tick_in), .core_tick_out(core_tick_out),
        .bus_tick_out(bus_tick_out), .dco_enable_out(dco_enable_out),
        .fll_ref_select_out(fll_ref_select_out),
        .fll_factor_out(fll_factor_out), .trim_out(trim_out),
        .lock_irq_out(lock_irq_out),
        .osc_monitor_enable_out(osc_monitor_enable_out),
        .osc_enable_out(osc_enable_out));

    always #2 mclk_in = ~mclk_in;
    always @(posedge mclk_in) osc_tick_in <= ~osc_tick_in;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Classic single cycle; waits for ack, the watchdog bounds the wait
    task automatic bus(input logic [7:0] idx, input logic we,
                       input logic [7:0] d, output logic [31:0] q);
        @(posedge mclk_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in <= we;
        wb_adr_in <= {idx, 2'b00};
        wb_dat_in <= {24'h00_0000, d};
        do begin
            @(posedge mclk_in);
        end while (wb_ack_out !== 1'b1);
        q = wb_dat_out;
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
        wb_we_in <= 1'b0;
        @(posedge mclk_in);
        check(wb_ack_out, 1'b0);
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(idx, 1'b1, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] q;
        bus(idx, 1'b0, 8'h00, q);
        check(q, {24'h00_0000, exp});
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(negedge mclk_in);
    endtask : idle

    task automatic set_in(input int which, input logic v);
        @(posedge mclk_in);
        case (which)
            ILA: illegal_access_in <= v;
            TOL: fll_in_tolerance_in <= v;
            default: stop_mode_in <= v;
        endcase
        idle(3);
    endtask : set_in

    // Gap between consecutive ticks, first partial gap skipped
    task automatic gap(input logic on_bus, input int exp);
        int g;
        int k;
        g = 0;
        for (k = 0; k < 3; k++) begin
            g = 0;
            do begin
                @(negedge mclk_in);
                g++;
            end while ((on_bus ? bus_tick_out : core_tick_out) !== 1'b1
                       && g < 100);
        end
        check(g, exp);
    endtask : gap

    task automatic do_reset(input logic p);
        @(posedge mclk_in);
        nrst_in <= 1'b0;
        por_in <= p;
        repeat (2) @(posedge mclk_in);
        nrst_in <= 1'b1;
        por_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
    endtask : do_reset

    task automatic tally_and_finish;
        if (n_mismatch == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20000) @(posedge mclk_in);
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        do_reset(1'b1);
        idle(1);
        check(trim_out, 9'h1a5);
        check(fll_factor_out, 11'h3e8);
        check(dco_enable_out, 1'b1);
        rd(FLAGS, 8'h40);
        rd(TRIMH, 8'h01);
        rd(TRIML, 8'ha5);
        wr(TRIMH, 8'hfe);
        rd(TRIMH, 8'h00);
        wr(FLAGS, 8'h00);
        rd(FLAGS, 8'h40);
        wr(FLAGS, 8'h40);
        rd(FLAGS, 8'h00);
        set_in(ILA, 1'b1);
        wr(FLAGS, 8'h04);
        set_in(ILA, 1'b0);
        rd(FLAGS, 8'h04);
        do_reset(1'b0);
        idle(1);
        check(trim_out, 9'h1a5);
        rd(FLAGS, 8'h04);
        wr(FLAGS, 8'h04);
        rd(FLAGS, 8'h00);
        set_in(ILA, 1'b1);
        set_in(ILA, 1'b0);
        do_reset(1'b1);
        rd(FLAGS, 8'h40);
        wr(FLAGS, 8'h40);
        rd(8'hff, 8'h00);
        wr(8'hff, 8'hff);
        rd(8'hff, 8'h00);
        wr(CTL1, 8'hff);
        rd(CTL1, 8'hf2);
        wr(MULT, 8'hff);
        rd(MULT, 8'h7f);
        idle(2);
        check(fll_factor_out, 11'h4e6);
        wb_sel_in <= 4'he;
        wr(MULT, 8'h00);
        wb_sel_in <= 4'hf;
        rd(MULT, 8'h7f);
        for (i = 0; i < 5; i++) begin
            wr(CTL1, {codes[i], 4'h0});
            gap(1'b0, divs[i]);
            gap(1'b1, 2 * divs[i]);
        end
        wr(CTL1, 8'h02);
        set_in(TOL, 1'b1);
        rd(FLAGS, 8'h18);
        check(lock_irq_out, 1'b1);
        wr(FLAGS, 8'h10);
        rd(FLAGS, 8'h08);
        idle(2);
        check(lock_irq_out, 1'b0);
        wr(MULT, 8'h10);
        rd(FLAGS, 8'h00);
        idle(2);
        check(fll_factor_out, 11'h408);
        set_in(TOL, 1'b0);
        set_in(TOL, 1'b1);
        rd(FLAGS, 8'h18);
        wr(FLAGS, 8'h10);
        set_in(TOL, 1'b0);
        rd(FLAGS, 8'h10);
        wr(CTL1, 8'h00);
        idle(2);
        check(lock_irq_out, 1'b0);
        wr(FLAGS, 8'h10);
        set_in(TOL, 1'b1);
        wr(FLAGS, 8'h10);
        set_in(STOP, 1'b1);
        rd(FLAGS, 8'h00);
        set_in(STOP, 1'b0);
        set_in(TOL, 1'b0);
        set_in(TOL, 1'b1);
        wr(FLAGS, 8'h10);
        wr(TRIML, 8'ha5);
        rd(FLAGS, 8'h00);
        set_in(TOL, 1'b0);
        wr(CTL0, 8'h8c);
        rd(CTL0, 8'h80);
        check(dco_enable_out, 1'b1);
        check(osc_monitor_enable_out, 1'b0);
        idle(20);
        rd(FLAGS, 8'h02);
        check(osc_monitor_enable_out, 1'b1);
        check(osc_enable_out, 1'b1);
        wr(CTL0, 8'h8c);
        rd(CTL0, 8'h8c);
        idle(2);
        check(dco_enable_out, 1'b0);
        check(fll_ref_select_out, 1'b1);
        wr(CTL1, 8'h10);
        gap(1'b0, 4);
        gap(1'b1, 8);
        set_in(STOP, 1'b1);
        rd(FLAGS, 8'h00);
        rd(CTL0, 8'h80);
        check(dco_enable_out, 1'b1);
        check(fll_ref_select_out, 1'b0);
        check(osc_monitor_enable_out, 1'b0);
        set_in(STOP, 1'b0);
        idle(20);
        rd(FLAGS, 8'h02);
        wr(CTL0, 8'h00);
        rd(FLAGS, 8'h00);
        tally_and_finish();
    end
endmodule : tb_clk_gen_regs
